// [logic/tcrb_pkg.sv]
package tcrb_pkg;

  // register offsets on the bus (byte addresses)
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_MODE   = 5'h04;
  localparam logic [4:0] OFS_RLD_LO = 5'h08;
  localparam logic [4:0] OFS_RLD_HI = 5'h0c;
  localparam logic [4:0] OFS_CNT_LO = 5'h10;
  localparam logic [4:0] OFS_CNT_HI = 5'h14;
  localparam logic [4:0] OFS_IEN    = 5'h18;

  // control_reg field positions
  localparam int CB_OVF  = 7;
  localparam int CB_EXF  = 6;
  localparam int CB_RXB  = 5;
  localparam int CB_TXB  = 4;
  localparam int CB_EXEN = 3;
  localparam int CB_RUN  = 2;
  localparam int CB_SRC  = 1;
  localparam int CB_CAP  = 0;

  // mode_reg and irq_enable_reg field positions
  localparam int MB_PRE  = 7;
  localparam int MB_COE  = 1;
  localparam int MB_UPDN = 0;
  localparam int IB_GIE  = 7;
  localparam int IB_TIE  = 5;

  // values after reset
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [7:0]  MODE_RST = 8'h00;
  localparam logic [7:0]  IEN_RST  = 8'h00;
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [15:0] RLD_RST  = 16'h0000;

  // counts
  localparam logic [15:0] CNT_MAX  = 16'hffff;
  localparam logic [3:0]  PRE_DIV  = 4'hc;
  localparam logic [5:0]  BDIV_TMR = 6'h20;
  localparam logic [5:0]  BDIV_PIN = 6'h10;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // operating mode: stopped, or running in capture, reload or baud
  typedef enum logic [1:0] {
    MD_STOP,
    MD_CAPTURE,
    MD_RELOAD,
    MD_BAUD
  } tcrb_mode_e;

endpackage : tcrb_pkg

// [logic/tcrb_edge_if.sv]
`timescale 1ns/100ps
interface tcrb_edge_if;
  logic trig_lvl;   // synchronised trigger pin level
  logic trig_fall;  // one-cycle pulse, trigger pin fell
  logic cnt_fall;   // one-cycle pulse, count pin fell
  modport src (output trig_lvl, output trig_fall, output cnt_fall);
  modport dst (input trig_lvl, input trig_fall, input cnt_fall);
endinterface : tcrb_edge_if

// [logic/tcrb_edge_sync.sv]
`timescale 1ns/100ps
module tcrb_edge_sync
  import tcrb_pkg::*;
(
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // raw pins
  input  wire logic ext_trigger_pin,
  input  wire logic count_clock_pin,
  // conditioned events
  tcrb_edge_if.src  eo
);

  logic [1:0] s1_r, s2_r, s3_r;  // stage 1, 2 and edge history
  logic [1:0] s1_nxt, s2_nxt, s3_nxt;

  // shift; stage 1 feeds only stage 2
  always_comb begin
    s1_nxt = {count_clock_pin, ext_trigger_pin};
    s2_nxt = s1_r;
    s3_nxt = s2_r;
  end

  // reset to high so the pulled-up idle pins give no false edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= 2'b11;
      s2_r <= 2'b11;
      s3_r <= 2'b11;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
    end
  end

  // each fall seen once: old sample high, new sample low
  assign eo.trig_lvl  = s2_r[0];
  assign eo.trig_fall = s3_r[0] & ~s2_r[0];
  assign eo.cnt_fall  = s3_r[1] & ~s2_r[1];

endmodule : tcrb_edge_sync

// [logic/tcrb_top.sv]
`timescale 1ns/100ps
// Notes on behaviour
// - sixteen-bit count advances only while running
// - source: system clock or count pin edges
// - capture, reload, baud chosen by select bits
// - clock output with internal source, optional baud
// - stopped counter, trigger edge detection still live
// - capture: overflow flag, edge copies count
// - up/down enable resets to zero
// - reload: overflow sets flag, loads reload
// - enabled trigger edge also reloads, sets flag
// - up/down: trigger level sets direction, up
// - down: match reload underflows, loads all ones
// - up/down: event flag toggles, no interrupt
// - receive and transmit baud chosen independently
// - baud: overflow reloads, no interrupt
// - baud: trigger edge sets flag unless clock output on, no reload
// - baud tick divides overflows by 32 or 16
// - clock output: half-rate count, toggle on overflow
// - clock output: overflow raises no flag
// - both flags share one gated interrupt
// - flags set by hardware, cleared by software
// - prescale selects system clock or divide-by-12
// - overflow flag set only with baud off
module tcrb_top
  import tcrb_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address and data
  input  wire logic        s_axi_awvalid,
  output wire logic        s_axi_awready,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output wire logic        s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output wire logic [1:0]  s_axi_bresp,
  // axi4-lite read
  input  wire logic        s_axi_arvalid,
  output wire logic        s_axi_arready,
  input  wire logic [4:0]  s_axi_araddr,
  output wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output wire logic [31:0] s_axi_rdata,
  output wire logic [1:0]  s_axi_rresp,
  // pins
  input  wire logic        ext_trigger_pin,
  input  wire logic        count_clock_pin,
  output wire logic        clock_out_pin,
  output wire logic        clock_out_oe,
  // serial port baud side
  output wire logic        rx_from_t2,
  output wire logic        tx_from_t2,
  output wire logic        rx_baud_tick,
  output wire logic        tx_baud_tick,
  // shared timer interrupt request
  output wire logic        irq
);

  // byte-wide merge of a bus write into a register
  function automatic logic [7:0] wr_byte(input logic [7:0] old,
                                         input logic        hit,
                                         input logic [31:0] wd,
                                         input logic [3:0]  ws);
    wr_byte = (hit && ws[0]) ? wd[7:0] : old;
  endfunction : wr_byte

  tcrb_edge_if ed ();  // conditioned pin events

  tcrb_edge_sync u_sync (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .ext_trigger_pin (ext_trigger_pin),
    .count_clock_pin (count_clock_pin),
    .eo              (ed.src)
  );

  // ---------------- bus slave ----------------
  logic        aw_hold_r, aw_hold_nxt;   // address captured
  logic        w_hold_r,  w_hold_nxt;    // data captured
  logic [4:0]  awaddr_r,  awaddr_nxt;
  logic [31:0] wdata_r,   wdata_nxt;
  logic [3:0]  wstrb_r,   wstrb_nxt;
  logic        bvalid_r,  bvalid_nxt;
  logic [1:0]  bresp_r,   bresp_nxt;
  logic        rvalid_r,  rvalid_nxt;
  logic [31:0] rdata_r,   rdata_nxt;
  logic [1:0]  rresp_r,   rresp_nxt;
  logic        do_wr;                    // write applied this cycle
  logic        wr_map;                   // write address decodes

  // registers seen by software
  logic [7:0]  ctrl_r, ctrl_nxt;          // control_reg, flags apart
  logic [7:0]  mode_r, mode_nxt;          // mode_reg
  logic [7:0]  ien_r,  ien_nxt;           // irq_enable_reg
  logic [15:0] cnt_r,  cnt_nxt;           // cnt_hi:cnt_lo
  logic [15:0] rld_r,  rld_nxt;           // reload_hi:reload_lo
  logic        ovf_r,  ovf_nxt;           // overflow_flag
  logic        exf_r,  exf_nxt;           // ext_event_flag

  assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
  assign s_axi_wready  = ~w_hold_r & ~bvalid_r;
  assign s_axi_arready = ~rvalid_r;
  assign do_wr  = aw_hold_r & w_hold_r & ~bvalid_r;
  assign wr_map = (awaddr_r[1:0] == 2'b00) && (awaddr_r <= OFS_IEN);

  // register view; unmapped slots and reserved mode_reg bits read zero, irq_enable_reg reads back all bits written
  function automatic logic [7:0] rd_byte(input logic [4:0] a);
    unique case (a)
      OFS_CTRL:   rd_byte = {ovf_r, exf_r, ctrl_r[5:0]};
      OFS_MODE:   rd_byte = mode_r;
      OFS_RLD_LO: rd_byte = rld_r[7:0];
      OFS_RLD_HI: rd_byte = rld_r[15:8];
      OFS_CNT_LO: rd_byte = cnt_r[7:0];
      OFS_CNT_HI: rd_byte = cnt_r[15:8];
      OFS_IEN:    rd_byte = ien_r;
      default:    rd_byte = 8'h00;
    endcase
  endfunction : rd_byte

  // handshake: address and data in any order, answer after both
  always_comb begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt  = w_hold_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstrb_nxt  = s_axi_wstrb;
    end
    if (do_wr) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = wr_map ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = {24'h000000, rd_byte(s_axi_araddr)};
      rresp_nxt  = ((s_axi_araddr[1:0] == 2'b00) &&
                    (s_axi_araddr <= OFS_IEN)) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= 5'h00;
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h00000000;
      rresp_r   <= RESP_OKAY;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r  <= w_hold_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

  // ---------------- mode decode ----------------
  logic       run, src, baud, clkout, cap_sel, rl_sel, ud;
  logic       pre_hit, step, fall, ovf_ev, und_ev;
  logic       wr_ctrl, wr_cnt_lo, wr_cnt_hi;
  logic       half_r, half_nxt;          // halves rate for clock out
  logic [3:0] pre_r, pre_nxt;            // divide-by-12 prescaler
  tcrb_mode_e md;

  assign run     = ctrl_r[CB_RUN];
  assign src     = ctrl_r[CB_SRC];
  assign baud    = ctrl_r[CB_RXB] | ctrl_r[CB_TXB];
  assign clkout  = mode_r[MB_COE] & ~src;
  assign cap_sel = ctrl_r[CB_CAP] & ~baud & ~clkout;
  assign rl_sel  = ~ctrl_r[CB_CAP] & ~baud & ~clkout;
  assign ud      = rl_sel & mode_r[MB_UPDN];
  assign md      = !run ? MD_STOP : baud ? MD_BAUD :
                   cap_sel ? MD_CAPTURE : MD_RELOAD;
  assign pre_hit = (pre_r == PRE_DIV - 4'h1);

  // count tick: pin falls, half rate for clock out, else every clock or prescaled
  always_comb begin
    if (src)                 step = ed.cnt_fall;
    else if (clkout)         step = half_r;
    else if (mode_r[MB_PRE]) step = pre_hit;
    else                     step = 1'b1;
    // stopped mode masks the tick of every source, pin and prescaler alike
    step = step & (md != MD_STOP);
  end

  // enabled trigger edge; ignored in up/down, live when stopped
  assign fall = ed.trig_fall & ctrl_r[CB_EXEN] & ~ud;

  assign wr_ctrl   = do_wr && awaddr_r == OFS_CTRL && wstrb_r[0];
  assign wr_cnt_lo = do_wr && awaddr_r == OFS_CNT_LO && wstrb_r[0];
  assign wr_cnt_hi = do_wr && awaddr_r == OFS_CNT_HI && wstrb_r[0];

  // ---------------- counter, reload and flags ----------------
  always_comb begin
    cnt_nxt  = cnt_r;
    rld_nxt  = rld_r;
    ovf_ev   = 1'b0;
    und_ev   = 1'b0;
    pre_nxt  = pre_hit ? 4'h0 : pre_r + 4'h1;
    half_nxt = clkout & run & ~half_r;
    if (step) begin
      if (ud && !ed.trig_lvl) begin
        if (cnt_r == rld_r) begin
          cnt_nxt = CNT_MAX;
          und_ev  = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 16'h0001;
        end
      end else if (cnt_r == CNT_MAX) begin
        ovf_ev  = 1'b1;
        // capture wraps; every other mode reloads
        cnt_nxt = cap_sel ? 16'h0000 : rld_r;
      end else begin
        cnt_nxt = cnt_r + 16'h0001;
      end
    end
    // edge actions: capture copies, plain reload reloads
    if (fall && cap_sel) rld_nxt = cnt_r;
    if (fall && rl_sel)  cnt_nxt = rld_r;
    // software writes take the word in the cycle they land
    if (wr_cnt_lo) cnt_nxt[7:0]  = wdata_r[7:0];
    if (wr_cnt_hi) cnt_nxt[15:8] = wdata_r[7:0];
    rld_nxt[7:0]  = wr_byte(rld_nxt[7:0],
                            do_wr && awaddr_r == OFS_RLD_LO,
                            wdata_r, wstrb_r);
    rld_nxt[15:8] = wr_byte(rld_nxt[15:8],
                            do_wr && awaddr_r == OFS_RLD_HI,
                            wdata_r, wstrb_r);
    ctrl_nxt = wr_byte(ctrl_r, wr_ctrl, wdata_r, wstrb_r);
    mode_nxt = wr_byte(mode_r, do_wr && awaddr_r == OFS_MODE,
                       wdata_r, wstrb_r) & 8'h83;
    ien_nxt  = wr_byte(ien_r, do_wr && awaddr_r == OFS_IEN,
                       wdata_r, wstrb_r);
    // flags: software writes either value, hardware set wins
    ovf_nxt = wr_ctrl ? wdata_r[CB_OVF] : ovf_r;
    exf_nxt = wr_ctrl ? wdata_r[CB_EXF] : exf_r;
    if ((ovf_ev || und_ev) && !baud && !clkout)
      ovf_nxt = 1'b1;
    if (fall && !clkout)
      exf_nxt = 1'b1;
    if (ud && (ovf_ev || und_ev))
      exf_nxt = ~exf_r;
  end

  // up/down enable and all control clear at reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RST;
      mode_r <= MODE_RST;
      ien_r  <= IEN_RST;
      cnt_r  <= CNT_RST;
      rld_r  <= RLD_RST;
      ovf_r  <= 1'b0;
      exf_r  <= 1'b0;
      pre_r  <= 4'h0;
      half_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      mode_r <= mode_nxt;
      ien_r  <= ien_nxt;
      cnt_r  <= cnt_nxt;
      rld_r  <= rld_nxt;
      ovf_r  <= ovf_nxt;
      exf_r  <= exf_nxt;
      pre_r  <= pre_nxt;
      half_r <= half_nxt;
    end
  end

  // ---------------- baud ticks and clock output ----------------
  logic [5:0] bdiv_r, bdiv_nxt;          // overflows since last tick
  logic       btick_r, btick_nxt;        // registered baud pulse
  logic       cko_r, cko_nxt;            // clock output level
  logic [5:0] bdiv_lim;

  // internal clock runs at half rate in clock out, so 16 there too
  assign bdiv_lim = (src | clkout) ? BDIV_PIN : BDIV_TMR;

  always_comb begin
    bdiv_nxt  = bdiv_r;
    btick_nxt = 1'b0;
    cko_nxt   = clkout ? cko_r : 1'b0;
    if (ovf_ev && baud) begin
      if (bdiv_r >= bdiv_lim - 6'h01) begin
        bdiv_nxt  = 6'h00;
        btick_nxt = 1'b1;
      end else begin
        bdiv_nxt = bdiv_r + 6'h01;
      end
    end
    if (ovf_ev && clkout) cko_nxt = ~cko_r;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bdiv_r  <= 6'h00;
      btick_r <= 1'b0;
      cko_r   <= 1'b0;
    end else begin
      bdiv_r  <= bdiv_nxt;
      btick_r <= btick_nxt;
      cko_r   <= cko_nxt;
    end
  end

  assign rx_from_t2    = ctrl_r[CB_RXB];
  assign tx_from_t2    = ctrl_r[CB_TXB];
  assign rx_baud_tick  = btick_r & ctrl_r[CB_RXB];
  assign tx_baud_tick  = btick_r & ctrl_r[CB_TXB];
  assign clock_out_pin = cko_r;
  assign clock_out_oe  = clkout;
  // event flag is the 17th count bit in up/down, so masked there
  assign irq = ien_r[IB_GIE] & ien_r[IB_TIE] &
               (ovf_r | (exf_r & ~ud));

  // ---------------- checks ----------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_stop_holds: assert property (
    !run && !do_wr && !fall |=> cnt_r == $past(cnt_r))
    else $error("count moved while stopped");

  chk_capture_copy: assert property (
    fall && cap_sel && !do_wr |=> rld_r == $past(cnt_r) && exf_r)
    else $error("capture did not copy count");

  chk_ovf_reload: assert property (
    step && rl_sel && !ud && !fall && !do_wr && cnt_r == CNT_MAX
    |=> cnt_r == $past(rld_r) && ovf_r)
    else $error("overflow did not reload");

  chk_down_under: assert property (
    step && ud && !ed.trig_lvl && cnt_r == rld_r && !do_wr
    |=> cnt_r == CNT_MAX && ovf_r)
    else $error("underflow did not load all ones");

  chk_exf_toggle: assert property (
    ud && (ovf_ev || und_ev) && !wr_ctrl |=> exf_r != $past(exf_r))
    else $error("event flag did not toggle");

  chk_baud_noflag: assert property (
    baud && !ovf_r && !wr_ctrl |=> !ovf_r)
    else $error("overflow flag set in baud mode");

  chk_irq_share: assert property (
    ien_r[IB_GIE] && ien_r[IB_TIE] && ovf_r |-> irq)
    else $error("interrupt not raised");

  chk_flag_sticky: assert property (
    ovf_r && !wr_ctrl |=> ovf_r)
    else $error("overflow flag cleared by hardware");

  chk_clkout_pin: assert property (
    clkout && ovf_ev |=> clock_out_pin != $past(clock_out_pin))
    else $error("clock output did not toggle");

endmodule : tcrb_top

// [sim/tcrb_pin_model.sv]
`timescale 1ns/100ps
module tcrb_pin_model (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // design outputs watched by the serial side
  input  wire logic rx_baud_tick,
  input  wire logic tx_baud_tick,
  input  wire logic clock_out_pin,
  // pins driven into the timer
  output logic      ext_trigger_pin,
  output logic      count_clock_pin
);
  int   cyc = 0;                     // free cycle count
  int   rx_last = 0, tx_last = 0;    // cycle of last tick
  int   rx_per = 0, tx_per = 0;      // last tick spacing
  int   co_rise = 0, co_per = 0;     // clock out rise spacing
  int   co_hi = 0;                   // clock out high time
  logic co_q = 1'b0;                 // previous clock out level

  // both pins idle high, as with the pull-up on the board
  initial begin
    ext_trigger_pin = 1'b1;
    count_clock_pin = 1'b1;
  end

  // spacing of ticks and clock out edges, as a receiver sees them
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    co_q <= clock_out_pin;
    if (rx_baud_tick === 1'b1) begin
      rx_per <= cyc - rx_last;
      rx_last <= cyc;
    end
    if (tx_baud_tick === 1'b1) begin
      tx_per <= cyc - tx_last;
      tx_last <= cyc;
    end
    if (clock_out_pin === 1'b1 && co_q === 1'b0) begin
      co_per <= cyc - co_rise;
      co_rise <= cyc;
    end
    if (clock_out_pin === 1'b0 && co_q === 1'b1) co_hi <= cyc - co_rise;
  end

  // levels held 4 cycles so two sync flops surely see each one
  task automatic trig_fall();
    ext_trigger_pin <= 1'b0;
    repeat (4) @(posedge aclk);
    ext_trigger_pin <= 1'b1;
    repeat (4) @(posedge aclk);
  endtask : trig_fall

  // direction level for up/down counting
  task automatic set_dir(input logic v);
    ext_trigger_pin <= v;
    repeat (4) @(posedge aclk);
  endtask : set_dir

  // n falling edges on the count pin, then idle high
  task automatic pulse_cnt(input int n);
    repeat (n) begin
      count_clock_pin <= 1'b0;
      repeat (4) @(posedge aclk);
      count_clock_pin <= 1'b1;
      repeat (4) @(posedge aclk);
    end
  endtask : pulse_cnt
endmodule : tcrb_pin_model

// [sim/testbench.sv]
`timescale 1ns/100ps
module testbench
  import tcrb_pkg::*;
();
  // bus master side, response readies raised only while waiting
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_bready = 1'b0, s_axi_rready = 1'b0;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire logic   s_axi_arready, s_axi_rvalid;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  // pins and serial side
  wire logic   ext_trigger_pin, count_clock_pin, clock_out_pin;
  wire logic   clock_out_oe, rx_from_t2, tx_from_t2;
  wire logic   rx_baud_tick, tx_baud_tick, irq;
  int          fails = 0, tests_run = 0, cyc = 0;
  logic [1:0]  bresp_q;              // last write answer

  always #5 aclk = ~aclk;

  tcrb_top tcrb_top_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .ext_trigger_pin, .count_clock_pin,
    .clock_out_pin, .clock_out_oe, .rx_from_t2, .tx_from_t2,
    .rx_baud_tick, .tx_baud_tick, .irq);

  tcrb_pin_model pins (.aclk, .aresetn, .rx_baud_tick, .tx_baud_tick,
    .clock_out_pin, .ext_trigger_pin, .count_clock_pin);

  task automatic wrap_up();
    if (fails == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [4:0] a, input logic [7:0] d,
                    input logic [3:0] s = 4'hf);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    bresp_q = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // one idle edge, so a following call never reassigns bready at once
    @(posedge aclk);
  endtask : wr

  // low byte first; the two halves are not latched together
  task automatic w16(input logic [4:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 5'h04, v[15:8]);
  endtask : w16

  task automatic rd_chk(input logic [4:0] a, input logic [7:0] d,
                        input logic [1:0] r = RESP_OKAY);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, {24'h0, d});
    chk(s_axi_rresp, r);
    s_axi_rready <= 1'b0;
    // one idle edge, so a following call never reassigns rready at once
    @(posedge aclk);
  endtask : rd_chk

  // hang guard, well above the few thousand cycles needed
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      wrap_up();
    end
  end

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    // every register clears on reset, gap slot refused
    for (int i = 0; i < 7; i++) rd_chk(5'(i * 4), 8'h00);
    rd_chk(5'h1c, 8'h00, RESP_SLVERR);
    rd_chk(5'h01, 8'h00, RESP_SLVERR);
    wr(5'h1c, 8'h5a);
    chk(bresp_q, RESP_SLVERR);
    // software set flag raises the shared request only when enabled
    wr(OFS_IEN, 8'ha0);
    wr(OFS_CTRL, 8'h40);
    chk(irq, 1'b1);
    wr(OFS_IEN, 8'h20);
    chk(irq, 1'b0);
    wr(OFS_IEN, 8'ha0);
    wr(OFS_CTRL, 8'h00);
    chk(irq, 1'b0);
    // a write without the low byte lane leaves the enables alone
    wr(OFS_IEN, 8'h00, 4'he);
    rd_chk(OFS_IEN, 8'ha0);
    // up count from all ones reloads and flags
    w16(OFS_RLD_LO, 16'h1234);
    w16(OFS_CNT_LO, 16'hffff);
    wr(OFS_CTRL, 8'h04);
    rd_chk(OFS_CNT_HI, 8'h12);
    rd_chk(OFS_CTRL, 8'h84);
    chk(irq, 1'b1);
    // pin counting, frozen once stopped; stop first so the count holds
    wr(OFS_CTRL, 8'h02);
    w16(OFS_CNT_LO, 16'h0000);
    wr(OFS_CTRL, 8'h06);
    pins.pulse_cnt(5);
    rd_chk(OFS_CNT_LO, 8'h05);
    wr(OFS_CTRL, 8'h02);
    pins.pulse_cnt(3);
    rd_chk(OFS_CNT_LO, 8'h05);
    // capture on trigger fall, stopped counter, gated by edge enable
    w16(OFS_CNT_LO, 16'habcd);
    wr(OFS_CTRL, 8'h01);
    pins.trig_fall();
    rd_chk(OFS_RLD_LO, 8'h34);
    rd_chk(OFS_CTRL, 8'h01);
    wr(OFS_CTRL, 8'h09);
    pins.trig_fall();
    rd_chk(OFS_RLD_LO, 8'hcd);
    rd_chk(OFS_RLD_HI, 8'hab);
    rd_chk(OFS_CTRL, 8'h49);
    // capture mode overflow wraps to zero and flags
    w16(OFS_CNT_LO, 16'hffff);
    wr(OFS_CTRL, 8'h05);
    rd_chk(OFS_CNT_HI, 8'h00);
    rd_chk(OFS_CTRL, 8'h85);
    // reload on trigger fall
    w16(OFS_CNT_LO, 16'h0001);
    wr(OFS_CTRL, 8'h08);
    pins.trig_fall();
    rd_chk(OFS_CNT_LO, 8'hcd);
    rd_chk(OFS_CNT_HI, 8'hab);
    rd_chk(OFS_CTRL, 8'h48);
    // up/down: down to reload then all ones, up wraps to reload
    wr(OFS_CTRL, 8'h00);
    w16(OFS_RLD_LO, 16'h0010);
    w16(OFS_CNT_LO, 16'h0013);
    wr(OFS_MODE, 8'h01);
    pins.set_dir(1'b0);
    wr(OFS_CTRL, 8'h06);
    pins.pulse_cnt(3);
    rd_chk(OFS_CNT_LO, 8'h10);
    pins.pulse_cnt(1);
    rd_chk(OFS_CNT_HI, 8'hff);
    rd_chk(OFS_CTRL, 8'hc6);
    pins.set_dir(1'b1);
    pins.pulse_cnt(1);
    rd_chk(OFS_CNT_LO, 8'h10);
    rd_chk(OFS_CTRL, 8'h86);
    wr(OFS_CTRL, 8'h46);
    chk(irq, 1'b0);
    wr(OFS_CTRL, 8'h00);
    wr(OFS_MODE, 8'h00);
    // baud: reload set while stopped so no tick is disturbed
    w16(OFS_RLD_LO, 16'hfffe);
    w16(OFS_CNT_LO, 16'hffff);
    for (int p = 0; p < 2; p++) begin
      wr(OFS_MODE, p ? 8'h80 : 8'h00);
      wr(OFS_CTRL, p ? 8'h24 : 8'h14);
      repeat (2000) @(posedge aclk);
      chk(p ? pins.rx_per : pins.tx_per, p ? 768 : 64);
      chk({rx_from_t2, tx_from_t2}, p ? 2'b10 : 2'b01);
      rd_chk(OFS_CTRL, p ? 8'h24 : 8'h14);
    end
    wr(OFS_CTRL, 8'h2c);
    pins.trig_fall();
    rd_chk(OFS_CTRL, 8'h6c);
    // clock out alone, then with receive baud taken from it
    wr(OFS_CTRL, 8'h00);
    wr(OFS_MODE, 8'h02);
    chk(clock_out_oe, 1'b1);
    wr(OFS_CTRL, 8'h04);
    repeat (100) @(posedge aclk);
    chk(pins.co_per, 8);
    chk(pins.co_hi, 4);
    rd_chk(OFS_CTRL, 8'h04);
    wr(OFS_CTRL, 8'h24);
    repeat (300) @(posedge aclk);
    chk(pins.rx_per, 64);
    wr(OFS_CTRL, 8'h00);
    wr(OFS_MODE, 8'h00);
    chk(clock_out_oe, 1'b0);
    wrap_up();
  end
endmodule : testbench
